// ---- rtl/brs_pkg.sv ----
package brs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESET_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG        = 8'h04;
  localparam logic [7:0] ADDR_OSC_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h14;
  localparam logic [7:0] ADDR_SEQ_STATUS    = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BROWNOUT_FLAG_BIT = 1;
  localparam int POR_FLAG_BIT      = 0;
  localparam int PLL_LOCK_BIT      = 5;
  localparam int CFG_OSC_SEL_LSB   = 0;
  localparam int CFG_POSC_MODE_LSB = 4;
  localparam int CFG_POWERUP_DELAY_TIMER_ZERO_BIT = 8;
  localparam int CFG_PLL_USE_BIT   = 9;
  localparam int CFG_XTAL_BIT      = 10;

  localparam int IRQ_BROWNOUT = 0;
  localparam int IRQ_RELEASE  = 1;
  localparam int IRQ_WIDTH    = 2;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam logic [1:0]  POSC_DISABLED = 2'b11;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 20;
  localparam int REG_STARTUP_US       = 20;
  localparam int REG_STARTUP_CYCLES   = (REG_STARTUP_US * 1000) / CLK_PERIOD_NS;
  localparam int FAIL_SAFE_DELAY      = 100;
  localparam int POWERUP_DELAY_US     = 64000;
  localparam int OSC_STARTUP_CYCLES_D = 1024;
  localparam int RESET_PULSE_CYCLES   = 4;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_REG_START = 5'b00001,
    ST_RST_PULSE = 5'b00010,
    ST_CLK_WAIT  = 5'b00100,
    ST_RUN       = 5'b01000,
    ST_POWERDOWN = 5'b10000
  } brs_state_e;

  typedef struct packed {
    logic [2:0] osc_select;
    logic [1:0] posc_mode;
    logic       powerup_delay_timer_zero;
    logic       pll_used;
    logic       xtal_used;
  } brs_cfg_s;

endpackage

// ---- rtl/brs_sequencer.sv ----
`timescale 1ns/10ps
// Summary of operation
// - after power-on, execution stays disabled for about 20 us while the core supply comes up.
// - the same start-up interval is applied again on every resume from power-down.
// - a detected brown-out produces a reset pulse that resets the whole device.
// - on brown-out the clock source is chosen from the oscillator select and mode fields.
// - for an oscillator mode the oscillator start-up timer runs and the clock is held until it ends.
// - with the PLL in use the clock is held until the PLL lock bit reads one.
// - the power-up delay runs alongside the clock wait; reset releases only after it ends.
// - with zero power-up delay and a crystal, a fail-safe delay of 100 is the whole delay.
// - the brown-out flag in the reset control register is set when a brown-out reset occurs.
// - brown-out detection stays active in sleep and idle and resets the device there.
module brs_sequencer
  import brs_pkg::*;
#(
  parameter int POWERUP_DELAY_CYCLES = (POWERUP_DELAY_US / CLK_PERIOD_NS) * 1000,
  parameter int OSC_STARTUP_CYCLES   = OSC_STARTUP_CYCLES_D,
  parameter int REG_STARTUP_CNT      = REG_STARTUP_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        brownout_detect,
  input  wire logic        powerdown_req,
  input  wire logic        wake_req,
  input  wire logic        sleep_mode,
  input  wire logic        idle_mode,
  input  wire logic        pll_lock_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             device_reset,
  output logic             exec_enable,
  output logic             sysclk_enable,
  output logic             irq
);

  initial begin
    if (POWERUP_DELAY_CYCLES < 1 || OSC_STARTUP_CYCLES < 1 || REG_STARTUP_CNT < 1)
      $error("brs_sequencer: delay counts must be at least one");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bod_sync;
  logic [1:0] pd_sync;
  logic [1:0] wake_sync;
  logic [1:0] slp_sync;
  logic [1:0] idl_sync;
  logic [1:0] lock_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bod_sync  <= 2'b00;
      pd_sync   <= 2'b00;
      wake_sync <= 2'b00;
      slp_sync  <= 2'b00;
      idl_sync  <= 2'b00;
      lock_sync <= 2'b00;
    end else begin
      bod_sync  <= {bod_sync[0], brownout_detect};
      pd_sync   <= {pd_sync[0], powerdown_req};
      wake_sync <= {wake_sync[0], wake_req};
      slp_sync  <= {slp_sync[0], sleep_mode};
      idl_sync  <= {idl_sync[0], idle_mode};
      lock_sync <= {lock_sync[0], pll_lock_in};
    end
  end

  wire brownout  = bod_sync[1];
  wire powerdown = pd_sync[1];
  wire wake      = wake_sync[1];
  wire low_power = slp_sync[1] | idl_sync[1];
  wire pll_lock  = lock_sync[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]          config_reg;
  logic                 brownout_flag;
  logic                 por_flag;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;

  brs_cfg_s cfg;
  assign cfg.osc_select = config_reg[CFG_OSC_SEL_LSB +: 3];
  assign cfg.posc_mode  = config_reg[CFG_POSC_MODE_LSB +: 2];
  assign cfg.powerup_delay_timer_zero  = config_reg[CFG_POWERUP_DELAY_TIMER_ZERO_BIT];
  assign cfg.pll_used   = config_reg[CFG_PLL_USE_BIT];
  assign cfg.xtal_used  = config_reg[CFG_XTAL_BIT];

  // ----------------------------------------------------------------
  // clock source choice
  // ----------------------------------------------------------------
  // osc select codes 2 and 3 take the primary oscillator, which is
  // only a real oscillator while its mode field is not disabled
  wire primary_sel = (cfg.osc_select == 3'h2) || (cfg.osc_select == 3'h3);
  wire osc_mode    = primary_sel && (cfg.posc_mode != POSC_DISABLED);
  wire pll_needed  = cfg.pll_used;
  wire fail_safe   = cfg.powerup_delay_timer_zero && cfg.xtal_used;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  brs_state_e state;
  brs_state_e next_state;
  logic [31:0] reg_cnt;
  logic [31:0] osc_cnt;
  logic [31:0] powerup_delay_timer_cnt;
  logic        from_brownout;

  wire reg_done  = (reg_cnt  == 32'h0000_0000);
  wire osc_done  = (osc_cnt  == 32'h0000_0000);
  wire powerup_delay_timer_done = (powerup_delay_timer_cnt == 32'h0000_0000);
  wire clk_ready = (!osc_mode || osc_done) && (!pll_needed || pll_lock);
  wire release_ok = clk_ready && powerup_delay_timer_done;

  // brownout wins from any state but ST_RST_PULSE, including sleep and idle
  always_comb begin
    next_state = state;
    unique case (state)
      ST_REG_START: if (reg_done) next_state = ST_RST_PULSE;
      ST_RST_PULSE: if (reg_done) next_state = ST_CLK_WAIT;
      ST_CLK_WAIT:  if (release_ok) next_state = ST_RUN;
      ST_RUN:       if (powerdown) next_state = ST_POWERDOWN;
      ST_POWERDOWN: if (wake) next_state = ST_REG_START;
    endcase
    if (brownout && state != ST_RST_PULSE) next_state = ST_RST_PULSE;
  end

  wire entering_pulse = (next_state == ST_RST_PULSE) && (state != ST_RST_PULSE);
  wire entering_start = (next_state == ST_REG_START) && (state != ST_REG_START);
  wire entering_wait  = (next_state == ST_CLK_WAIT) && (state != ST_CLK_WAIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= ST_REG_START;
      reg_cnt       <= 32'(REG_STARTUP_CNT - 1);
      osc_cnt       <= 32'h0000_0000;
      powerup_delay_timer_cnt      <= 32'h0000_0000;
      from_brownout <= 1'b0;
    end else begin
      state <= next_state;
      if (entering_start)
        reg_cnt <= 32'(REG_STARTUP_CNT - 1);
      else if (entering_pulse)
        reg_cnt <= 32'(RESET_PULSE_CYCLES - 1);
      else if (!reg_done)
        reg_cnt <= reg_cnt - 32'h0000_0001;
      if (entering_pulse)
        from_brownout <= brownout;
      if (entering_wait) begin
        osc_cnt  <= 32'(OSC_STARTUP_CYCLES);
        powerup_delay_timer_cnt <= fail_safe ? 32'(FAIL_SAFE_DELAY)
                  : (cfg.powerup_delay_timer_zero ? 32'h0000_0000 : 32'(POWERUP_DELAY_CYCLES));
      end else if (state == ST_CLK_WAIT) begin
        if (!osc_done)  osc_cnt  <= osc_cnt - 32'h0000_0001;
        if (!powerup_delay_timer_done) powerup_delay_timer_cnt <= powerup_delay_timer_cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_reset  <= 1'b1;
      exec_enable   <= 1'b0;
      sysclk_enable <= 1'b0;
    end else begin
      device_reset  <= (next_state != ST_RUN) && (next_state != ST_POWERDOWN);
      exec_enable   <= (next_state == ST_RUN);
      sysclk_enable <= (next_state == ST_RUN) ||
                       ((next_state == ST_CLK_WAIT) && clk_ready);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire rd_take  = s_axi_arvalid && s_axi_arready;

  function automatic logic [31:0] merge_word(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  wire wr_cfg   = wr_fire && (aw_addr == ADDR_CONFIG);
  wire wr_reset_control_reg  = wr_fire && (aw_addr == ADDR_RESET_CONTROL);
  wire wr_ien   = wr_fire && (aw_addr == ADDR_IRQ_ENABLE);
  wire wr_iclr  = wr_fire && (aw_addr == ADDR_IRQ_CLEAR);
  wire wr_known = wr_cfg || wr_reset_control_reg || wr_ien || wr_iclr;

  wire [31:0] new_word  = merge_word(ZERO_WORD, w_data, w_strb);
  // writing a one clears a reset cause flag
  wire clr_bo  = wr_reset_control_reg && new_word[BROWNOUT_FLAG_BIT];
  wire clr_por = wr_reset_control_reg && new_word[POR_FLAG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= ZERO_WORD;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // the reset cause flags live on the bus reset only, so they survive
  // the device reset that the sequencer drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg    <= CONFIG_RESET;
      brownout_flag <= 1'b0;
      por_flag      <= 1'b1;
      irq_enable    <= '0;
      irq_status    <= '0;
    end else begin
      if (wr_cfg) config_reg <= merge_word(config_reg, w_data, w_strb);
      if (wr_ien) irq_enable <= new_word[IRQ_WIDTH-1:0];
      if (brownout) brownout_flag <= 1'b1;
      else if (clr_bo) brownout_flag <= 1'b0;
      if (clr_por) por_flag <= 1'b0;
      irq_status <= (irq_status & ~(wr_iclr ? new_word[IRQ_WIDTH-1:0] : '0))
                  | {(state == ST_CLK_WAIT) && (next_state == ST_RUN),
                     entering_pulse && brownout};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(irq_status & irq_enable);
  end

  logic [31:0] rd_word;
  always_comb begin
    rd_word = ZERO_WORD;
    unique case (s_axi_araddr)
      ADDR_RESET_CONTROL: begin
        rd_word[BROWNOUT_FLAG_BIT] = brownout_flag;
        rd_word[POR_FLAG_BIT]      = por_flag;
      end
      ADDR_CONFIG:      rd_word = config_reg;
      ADDR_OSC_CONTROL: rd_word[PLL_LOCK_BIT] = pll_lock;
      ADDR_IRQ_STATUS:  rd_word[IRQ_WIDTH-1:0] = irq_status;
      ADDR_IRQ_ENABLE:  rd_word[IRQ_WIDTH-1:0] = irq_enable;
      ADDR_SEQ_STATUS:  rd_word = {26'h000_0000, from_brownout, state};
      default:          rd_word = ZERO_WORD;
    endcase
  end

  wire rd_known = (s_axi_araddr == ADDR_RESET_CONTROL) || (s_axi_araddr == ADDR_CONFIG) ||
                  (s_axi_araddr == ADDR_OSC_CONTROL) || (s_axi_araddr == ADDR_IRQ_STATUS) ||
                  (s_axi_araddr == ADDR_IRQ_ENABLE) || (s_axi_araddr == ADDR_SEQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- verification/brs_sequencer_checker.sv ----
`timescale 1ns/10ps
module brs_sequencer_checker
  import brs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brownout_detect,
  input wire logic wake_req,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic device_reset,
  input wire logic exec_enable,
  input wire logic sysclk_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  // reset itself must force the safe state, so this one is never disabled
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=> device_reset && !exec_enable && !sysclk_enable)
    else $error("outputs not safe during reset");
  a_startup_hold: assert property ($rose(aresetn) |-> !exec_enable [*8])
    else $error("execution enabled during regulator start-up");
  a_resume_hold: assert property ($rose(wake_req) |-> !exec_enable [*8])
    else $error("execution enabled too early after resume");
  a_brownout_reset: assert property ($rose(brownout_detect) |-> ##[1:8] device_reset)
    else $error("no reset after brown-out");
  a_pulse_length: assert property ($rose(device_reset) |-> device_reset [*4])
    else $error("reset pulse too short");
  a_sleep_brownout: assert property ((sleep_mode || idle_mode) && $rose(brownout_detect)
    |-> ##[1:8] device_reset)
    else $error("brown-out ignored in low-power mode");
  a_run_clock_on: assert property (exec_enable |-> sysclk_enable && !device_reset)
    else $error("running with clock gated or reset held");
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  c_release: cover property ($rose(exec_enable));
  c_sleep_bo: cover property ($rose(device_reset) && sleep_mode);
  c_wake: cover property ($rose(wake_req));
endmodule

bind brs_sequencer brs_sequencer_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .brownout_detect(brownout_detect), .wake_req(wake_req), .sleep_mode(sleep_mode),
  .idle_mode(idle_mode), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .device_reset(device_reset), .exec_enable(exec_enable), .sysclk_enable(sysclk_enable));

// ---- verification/brs_sequencer_tb_top.sv ----
`timescale 1ns/10ps
module brs_sequencer_tb_top
  import brs_pkg::*;
;
  // short counts keep the run brief; expectations derive from them
  localparam int PUD = 50;
  localparam int REG = 10;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } brs_row_s;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        brownout_detect = 1'b0, powerdown_req = 1'b0, wake_req = 1'b0;
  logic        sleep_mode = 1'b0, idle_mode = 1'b0, pll_lock_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        device_reset, exec_enable, sysclk_enable, irq;
  logic [31:0] rd;
  int          error_cnt = 0, num_checks = 0, cyc = 0, n;
  brs_row_s    rows [10] = '{
    '{1'b1, ADDR_CONFIG, 32'h0000_0013, 32'h0000_0000, RESP_OKAY},
    '{1'b0, ADDR_CONFIG, 32'h0000_0013, 32'h0000_0737, RESP_OKAY},
    '{1'b1, ADDR_OSC_CONTROL, 32'h0000_FFFF, 32'h0000_0000, RESP_SLVERR},
    '{1'b1, ADDR_SEQ_STATUS, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR},
    '{1'b0, 8'h3C, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR},
    '{1'b1, ADDR_IRQ_ENABLE, 32'h0000_0003, 32'h0000_0000, RESP_OKAY},
    '{1'b0, ADDR_IRQ_ENABLE, 32'h0000_0003, 32'h0000_0003, RESP_OKAY},
    '{1'b0, ADDR_OSC_CONTROL, 32'h0000_0000, 32'h0000_0020, RESP_OKAY},
    '{1'b0, ADDR_RESET_CONTROL, 32'h0000_0000, 32'h0000_0002, RESP_OKAY},
    '{1'b0, ADDR_SEQ_STATUS, 32'h0000_0008, 32'h0000_001F, RESP_OKAY}};

  brs_sequencer #(.POWERUP_DELAY_CYCLES(PUD), .OSC_STARTUP_CYCLES(16), .REG_STARTUP_CNT(REG))
  dut (.aclk(aclk), .aresetn(aresetn), .brownout_detect(brownout_detect),
    .powerdown_req(powerdown_req), .wake_req(wake_req), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .pll_lock_in(pll_lock_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .device_reset(device_reset), .exec_enable(exec_enable), .sysclk_enable(sysclk_enable),
    .irq(irq));

  always #10 aclk = ~aclk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_exec(input logic lvl);
    n = 0;
    while (exec_enable !== lvl && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    // a sequencer that never settles is a failure, not a long wait
    if (n >= 3000) error_cnt++;
  endtask

  // a short brown-out, then wait for the reset it must cause
  task automatic brownout();
    @(posedge aclk);
    brownout_detect <= 1'b1;
    repeat (3) @(posedge aclk);
    brownout_detect <= 1'b0;
    n = 0;
    while (device_reset !== 1'b1 && n < 8) begin
      @(posedge aclk);
      n++;
    end
    check("bo_reset", 32'(device_reset), 32'h1);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    check("reset_out", 32'({device_reset, exec_enable, sysclk_enable, irq}), 32'h8);
    aresetn <= 1'b1;
    wait_exec(1'b1);
    check("startup_len", 32'(n >= REG + 4 + PUD), 32'h1);
    for (int i = 0; i < 10; i++) begin
      if (rows[i].wr) axi_wr(rows[i].addr, rows[i].data);
      else axi_rd(rows[i].addr);
      check("row_resp", 32'(resp), 32'(rows[i].resp));
      if (!rows[i].wr) check("row_data", rd & rows[i].mask, rows[i].data);
    end
    sleep_mode <= 1'b1;
    brownout();
    sleep_mode <= 1'b0;
    wait_exec(1'b1);
    axi_rd(ADDR_RESET_CONTROL);
    check("bo_flag", rd & 32'h0000_0002, 32'h0000_0002);
    check("irq_set", 32'(irq), 32'h1);
    axi_wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    // irq is registered one cycle behind the enable it reflects
    repeat (2) @(posedge aclk);
    check("irq_mask", 32'(irq), 32'h0);
    axi_wr(ADDR_IRQ_ENABLE, 32'h0000_0003);
    axi_wr(ADDR_IRQ_CLEAR, 32'h0000_0003);
    axi_wr(ADDR_RESET_CONTROL, 32'h0000_0002);
    axi_rd(ADDR_RESET_CONTROL);
    check("flag_clear", rd & 32'h0000_0002, 32'h0);
    check("irq_clear", 32'(irq), 32'h0);
    axi_wr(ADDR_CONFIG, 32'h0000_0202);
    brownout();
    repeat (300) @(posedge aclk);
    check("pll_hold", 32'({exec_enable, sysclk_enable}), 32'h0);
    pll_lock_in <= 1'b1;
    wait_exec(1'b1);
    check("pll_release", 32'(n < 20), 32'h1);
    axi_wr(ADDR_CONFIG, 32'h0000_0502);
    brownout();
    wait_exec(1'b1);
    check("fail_safe", 32'(n >= 100), 32'h1);
    axi_wr(ADDR_CONFIG, 32'h0000_0000);
    powerdown_req <= 1'b1;
    wait_exec(1'b0);
    powerdown_req <= 1'b0;
    repeat (5) @(posedge aclk);
    wake_req <= 1'b1;
    wait_exec(1'b1);
    wake_req <= 1'b0;
    check("resume_len", 32'(n >= REG + 4), 32'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(ADDR_CONFIG);
    check("cfg_reset", rd, CONFIG_RESET);
    print_verdict();
  end
endmodule
